// ---- hw/bjdu_defines.vh ----
// Purpose: constants shared by the branch/jump/call sequencer
// Assumes: 8-bit core, 16-bit program counter, byte-wide data memory
// Notes:   cycle figures are the not-taken counts; a taken relative
//          branch adds BJDU_TAKEN_EXTRA cycles
`ifndef BJDU_DEFINES_VH
`define BJDU_DEFINES_VH

// flag-tested relative branch opcodes, then the other fixed branch, jump and call opcodes
`define BJDU_OP_CARRY_ZERO     8'h50
`define BJDU_OP_CARRY_ONE      8'hd0
`define BJDU_OP_ZERO_FLAG_ONE  8'hf0
`define BJDU_OP_ZERO_FLAG_ZERO 8'h70
`define BJDU_OP_NEGATIVE       8'h90
`define BJDU_OP_NONNEGATIVE    8'h10
`define BJDU_OP_OVERFLOW_ZERO  8'h30
`define BJDU_OP_OVERFLOW_ONE   8'hb0
`define BJDU_OP_UNCOND         8'h2f
`define BJDU_OP_CALL_ABS       8'h3b
`define BJDU_OP_CALL_DP        8'h5f
`define BJDU_OP_CMP_DP         8'hfd
`define BJDU_OP_CMP_DPX        8'h8d
`define BJDU_OP_DEC_DP         8'hac
`define BJDU_OP_DEC_Y          8'h7b
`define BJDU_OP_JMP_ABS        8'h1b
`define BJDU_OP_JMP_IABS       8'h1f
`define BJDU_OP_JMP_DP         8'h3f
`define BJDU_OP_UPAGE          8'h4f
// low nibbles of families with a field in the high nibble
`define BJDU_LO_BIT_ACC        4'h2
`define BJDU_LO_BIT_DP         4'h3
`define BJDU_LO_TABLE          4'ha

// instruction kinds
`define BJDU_K_BAD      4'h0
`define BJDU_K_BIT_ACC  4'h1
`define BJDU_K_BIT_DP   4'h2
`define BJDU_K_FLAG     4'h3
`define BJDU_K_UNCOND   4'h4
`define BJDU_K_CALL_ABS 4'h5
`define BJDU_K_CALL_DP  4'h6
`define BJDU_K_CMP_DP   4'h7
`define BJDU_K_CMP_DPX  4'h8
`define BJDU_K_DEC_DP   4'h9
`define BJDU_K_DEC_Y    4'ha
`define BJDU_K_JMP_ABS  4'hb
`define BJDU_K_JMP_IABS 4'hc
`define BJDU_K_JMP_DP   4'hd
`define BJDU_K_UPAGE    4'he
`define BJDU_K_TABLE    4'hf

// instruction lengths in bytes
`define BJDU_LEN1 2'h1
`define BJDU_LEN2 2'h2
`define BJDU_LEN3 2'h3

// base cycle counts
`define BJDU_CYC_BIT_ACC  4'h4
`define BJDU_CYC_BIT_DP   4'h5
`define BJDU_CYC_FLAG     4'h2
`define BJDU_CYC_UNCOND   4'h2
`define BJDU_CYC_CALL     4'h8
`define BJDU_CYC_CMP_DP   4'h5
`define BJDU_CYC_CMP_DPX  4'h6
`define BJDU_CYC_DEC_DP   4'h5
`define BJDU_CYC_DEC_Y    4'h4
`define BJDU_CYC_JMP_ABS  4'h3
`define BJDU_CYC_JMP_IABS 4'h5
`define BJDU_CYC_JMP_DP   4'h4
`define BJDU_CYC_UPAGE    4'h6
`define BJDU_CYC_TABLE    4'h8
`define BJDU_TAKEN_EXTRA  4'h2

// fixed address parts
`define BJDU_UPAGE_HIGH   8'hff
`define BJDU_STACK_PAGE   8'h01
`define BJDU_TVEC_BASE    16'hffc0

`endif

// ---- hw/bjdu_top.v ----
// Purpose: executes branch, jump and call instructions of the 8-bit core
// Assumes: opcode and operand bytes already fetched; data memory reads
//          combinationally (mem_rdata valid in the cycle mem_rd is high)
// Notes:   done marks the last cycle of the instruction's cycle count
//
// Behaviour
// RL1 - bit branches on accumulator or direct-page byte
// RL2 - carry-flag branches, opcodes 50 and d0
// RL3 - zero-flag branches, opcodes f0 and 70
// RL4 - negative-flag branches, opcodes 90 and 10
// RL5 - overflow-flag branches, opcodes 30 and b0
// RL6 - opcode 2f branches always, four cycles
// RL7 - calls push pc high, low, then load target
// RL8 - compare with direct byte, branch when different
// RL9 - decrement memory or y, branch when nonzero
// RL10 - absolute and indirect jumps load program counter
// RL11 - upper-page call forces high byte to ff
// RL12 - table call loads pc from selected vector
// RL13 - signed offset from next instruction; taken costs more
// RL14 - pushed address is next instruction, high byte higher
`timescale 1ns/1ps
`default_nettype none
`include "bjdu_defines.vh"

module bjdu_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire [7:0]  opcode,
  input  wire [7:0]  operand1,
  input  wire [7:0]  operand2,
  input  wire [15:0] pc_in,
  input  wire [7:0]  acc_in,
  input  wire [7:0]  x_in,
  input  wire [7:0]  y_in,
  input  wire [7:0]  sp_in,
  input  wire [7:0]  dp_page,
  input  wire        flag_c,
  input  wire        flag_z,
  input  wire        flag_n,
  input  wire        flag_v,
  input  wire [7:0]  mem_rdata,
  output reg         busy,
  output reg         done,
  output reg         taken,
  output reg         bad_op,
  output reg  [15:0] pc_out,
  output reg  [7:0]  sp_out,
  output reg  [7:0]  y_out,
  output reg         y_we,
  output reg  [15:0] mem_addr,
  output reg         mem_rd,
  output reg         mem_wr,
  output reg  [7:0]  mem_wdata
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_PUSHL = 3'h1;
  localparam [2:0] S_PUSHD = 3'h2;
  localparam [2:0] S_RQ1   = 3'h3;
  localparam [2:0] S_RQ2   = 3'h4;
  localparam [2:0] S_WAIT  = 3'h5;

  // returns {kind, length, base cycles}
  function [9:0] bjdu_decode;
    input [7:0] op;
    begin
      case (op)
        `BJDU_OP_CARRY_ZERO, `BJDU_OP_CARRY_ONE,
        `BJDU_OP_ZERO_FLAG_ONE, `BJDU_OP_ZERO_FLAG_ZERO,
        `BJDU_OP_NEGATIVE, `BJDU_OP_NONNEGATIVE,
        `BJDU_OP_OVERFLOW_ZERO, `BJDU_OP_OVERFLOW_ONE:
          bjdu_decode = {`BJDU_K_FLAG, `BJDU_LEN2, `BJDU_CYC_FLAG};
        `BJDU_OP_UNCOND:
          bjdu_decode = {`BJDU_K_UNCOND, `BJDU_LEN2, `BJDU_CYC_UNCOND};
        `BJDU_OP_CALL_ABS:
          bjdu_decode = {`BJDU_K_CALL_ABS, `BJDU_LEN3, `BJDU_CYC_CALL};
        `BJDU_OP_CALL_DP:
          bjdu_decode = {`BJDU_K_CALL_DP, `BJDU_LEN2, `BJDU_CYC_CALL};
        `BJDU_OP_CMP_DP:
          bjdu_decode = {`BJDU_K_CMP_DP, `BJDU_LEN3, `BJDU_CYC_CMP_DP};
        `BJDU_OP_CMP_DPX:
          bjdu_decode = {`BJDU_K_CMP_DPX, `BJDU_LEN3, `BJDU_CYC_CMP_DPX};
        `BJDU_OP_DEC_DP:
          bjdu_decode = {`BJDU_K_DEC_DP, `BJDU_LEN3, `BJDU_CYC_DEC_DP};
        `BJDU_OP_DEC_Y:
          bjdu_decode = {`BJDU_K_DEC_Y, `BJDU_LEN2, `BJDU_CYC_DEC_Y};
        `BJDU_OP_JMP_ABS:
          bjdu_decode = {`BJDU_K_JMP_ABS, `BJDU_LEN3, `BJDU_CYC_JMP_ABS};
        `BJDU_OP_JMP_IABS:
          bjdu_decode = {`BJDU_K_JMP_IABS, `BJDU_LEN3, `BJDU_CYC_JMP_IABS};
        `BJDU_OP_JMP_DP:
          bjdu_decode = {`BJDU_K_JMP_DP, `BJDU_LEN2, `BJDU_CYC_JMP_DP};
        `BJDU_OP_UPAGE:
          bjdu_decode = {`BJDU_K_UPAGE, `BJDU_LEN2, `BJDU_CYC_UPAGE};
        default: begin
          if (op[3:0] == `BJDU_LO_BIT_ACC)
            bjdu_decode = {`BJDU_K_BIT_ACC, `BJDU_LEN2, `BJDU_CYC_BIT_ACC};
          else if (op[3:0] == `BJDU_LO_BIT_DP)
            bjdu_decode = {`BJDU_K_BIT_DP, `BJDU_LEN3, `BJDU_CYC_BIT_DP};
          else if (op[3:0] == `BJDU_LO_TABLE)
            bjdu_decode = {`BJDU_K_TABLE, `BJDU_LEN1, `BJDU_CYC_TABLE};
          else
            bjdu_decode = {`BJDU_K_BAD, `BJDU_LEN1, `BJDU_CYC_FLAG};
        end
      endcase
    end
  endfunction

  function [15:0] bjdu_stack_addr;
    input [7:0] sp;
    begin
      bjdu_stack_addr = {`BJDU_STACK_PAGE, sp};
    end
  endfunction

  reg  [2:0]  state_reg;
  reg  [3:0]  cnt_reg;
  reg  [3:0]  kind_reg;
  reg  [7:0]  op_reg;
  reg  [7:0]  o1_reg;
  reg  [7:0]  o2_reg;
  reg  [7:0]  acc_reg;
  reg  [7:0]  sp_reg;
  reg  [7:0]  lo_reg;
  reg  [15:0] pcs_reg;
  reg  [15:0] a_reg;

  wire        idle = (state_reg == S_IDLE);
  wire [9:0]  dec  = bjdu_decode(opcode);
  wire [3:0]  k    = idle ? dec[9:6] : kind_reg;
  wire [7:0]  op   = idle ? opcode : op_reg;
  wire [7:0]  o1   = idle ? operand1 : o1_reg;
  wire [7:0]  o2   = idle ? operand2 : o2_reg;
  wire [7:0]  acc  = idle ? acc_in : acc_reg;
  wire [7:0]  sp   = idle ? sp_in : sp_reg;
  // return address and branch base: the byte after the instruction
  wire [15:0] pcs  = idle ? pc_in + {14'h0000, dec[5:4]} : pcs_reg; // [RL14]

  wire need_push = (k == `BJDU_K_CALL_ABS) || (k == `BJDU_K_CALL_DP) ||
                   (k == `BJDU_K_UPAGE) || (k == `BJDU_K_TABLE);
  wire two_rd    = (k == `BJDU_K_JMP_IABS) || (k == `BJDU_K_JMP_DP) ||
                   (k == `BJDU_K_CALL_DP) || (k == `BJDU_K_TABLE);
  wire need_rd   = two_rd || (k == `BJDU_K_BIT_DP) ||
                   (k == `BJDU_K_CMP_DP) || (k == `BJDU_K_CMP_DPX) ||
                   (k == `BJDU_K_DEC_DP);

  // first read address, only meaningful while idle
  reg [15:0] rd_addr;
  always @* begin
    case (dec[9:6])
      `BJDU_K_CMP_DPX:  rd_addr = {dp_page, operand1 + x_in}; // [RL8]
      `BJDU_K_JMP_IABS: rd_addr = {operand2, operand1};       // [RL10]
      `BJDU_K_TABLE:    rd_addr = `BJDU_TVEC_BASE +
                                  {11'h000, opcode[7:4], 1'b0}; // [RL12]
      default:          rd_addr = {dp_page, operand1};
    endcase
  end

  reg        fin_taken;
  reg        bitv;
  reg [7:0]  rel;
  reg [15:0] fin_pc;
  always @* begin
    fin_taken = 1'b0;
    bitv      = 1'b0;
    rel       = o2;
    fin_pc    = pcs;
    case (k)
      `BJDU_K_BIT_ACC: begin
        bitv      = acc[op[7:5]];
        fin_taken = op[4] ? ~bitv : bitv;                  // [RL1]
        rel       = o1;
      end
      `BJDU_K_BIT_DP: begin
        bitv      = mem_rdata[op[7:5]];
        fin_taken = op[4] ? ~bitv : bitv;                  // [RL1]
      end
      `BJDU_K_FLAG: begin
        rel = o1;
        case (op)
          `BJDU_OP_CARRY_ZERO:     fin_taken = ~flag_c;    // [RL2]
          `BJDU_OP_CARRY_ONE:      fin_taken = flag_c;     // [RL2]
          `BJDU_OP_ZERO_FLAG_ONE:  fin_taken = flag_z;     // [RL3]
          `BJDU_OP_ZERO_FLAG_ZERO: fin_taken = ~flag_z;    // [RL3]
          `BJDU_OP_NEGATIVE:       fin_taken = flag_n;     // [RL4]
          `BJDU_OP_NONNEGATIVE:    fin_taken = ~flag_n;    // [RL4]
          `BJDU_OP_OVERFLOW_ZERO:  fin_taken = ~flag_v;    // [RL5]
          default:                 fin_taken = flag_v;     // [RL5]
        endcase
      end
      `BJDU_K_UNCOND: begin
        fin_taken = 1'b1;                                  // [RL6]
        rel       = o1;
      end
      `BJDU_K_CMP_DP, `BJDU_K_CMP_DPX:
        fin_taken = (acc != mem_rdata);                    // [RL8]
      `BJDU_K_DEC_DP:
        fin_taken = (mem_rdata != 8'h01);                  // [RL9]
      `BJDU_K_DEC_Y: begin
        fin_taken = (y_in != 8'h01);                       // [RL9]
        rel       = o1;
      end
      `BJDU_K_JMP_ABS, `BJDU_K_CALL_ABS:
        fin_pc = {o2, o1};                                 // [RL7] [RL10]
      `BJDU_K_JMP_IABS, `BJDU_K_JMP_DP, `BJDU_K_CALL_DP, `BJDU_K_TABLE:
        fin_pc = {mem_rdata, lo_reg};               // [RL7] [RL10] [RL12]
      `BJDU_K_UPAGE:
        fin_pc = {`BJDU_UPAGE_HIGH, o1};                   // [RL11]
      default:
        fin_pc = pcs;
    endcase
    if (fin_taken)
      fin_pc = pcs + {{8{rel[7]}}, rel};                   // [RL13]
  end

  // remaining cycles; the idle base counts the start cycle itself
  wire [3:0] cnt_base = idle ? dec[3:0] - 4'h1 : cnt_reg;
  wire [3:0] fin_cnt  = cnt_base + (fin_taken ? `BJDU_TAKEN_EXTRA
                                              : 4'h0);     // [RL13]
  wire fin_go = (idle && start && (k != `BJDU_K_BAD) &&
                 !need_push && !need_rd) ||
                ((state_reg == S_PUSHD) && !need_rd) ||
                ((state_reg == S_RQ1) && !two_rd) ||
                (state_reg == S_RQ2);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      cnt_reg   <= 4'h0;
      kind_reg  <= `BJDU_K_BAD;
      op_reg    <= 8'h00;
      o1_reg    <= 8'h00;
      o2_reg    <= 8'h00;
      acc_reg   <= 8'h00;
      sp_reg    <= 8'h00;
      lo_reg    <= 8'h00;
      pcs_reg   <= 16'h0000;
      a_reg     <= 16'h0000;
      busy      <= 1'b0;
      done      <= 1'b0;
      taken     <= 1'b0;
      bad_op    <= 1'b0;
      pc_out    <= 16'h0000;
      sp_out    <= 8'h00;
      y_out     <= 8'h00;
      y_we      <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      done   <= 1'b0;
      y_we   <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            kind_reg <= dec[9:6];
            op_reg   <= opcode;
            o1_reg   <= operand1;
            o2_reg   <= operand2;
            acc_reg  <= acc_in;
            sp_reg   <= sp_in;
            pcs_reg  <= pcs;
            a_reg    <= rd_addr;
            taken    <= 1'b0;
            bad_op   <= 1'b0;
            busy     <= 1'b1;
            cnt_reg  <= dec[3:0] - 4'h2;
            if (k == `BJDU_K_BAD) begin
              // unknown opcode: leave pc alone and report it
              busy      <= 1'b0;
              done      <= 1'b1;
              bad_op    <= 1'b1;
              pc_out    <= pc_in;
              sp_out    <= sp_in;
            end else if (need_push) begin
              mem_wr    <= 1'b1;
              mem_addr  <= bjdu_stack_addr(sp_in);
              mem_wdata <= pcs[15:8];                // [RL7] [RL11] [RL12]
              state_reg <= S_PUSHL;
            end else if (need_rd) begin
              mem_rd    <= 1'b1;
              mem_addr  <= rd_addr;
              state_reg <= S_RQ1;
            end
          end
        end
        S_PUSHL: begin
          // low byte goes one below the high byte
          mem_wr    <= 1'b1;
          mem_addr  <= bjdu_stack_addr(sp_reg - 8'h01); // [RL14]
          mem_wdata <= pcs_reg[7:0];                 // [RL7] [RL11] [RL12]
          cnt_reg   <= cnt_reg - 4'h1;
          state_reg <= S_PUSHD;
        end
        S_PUSHD: begin
          if (need_rd) begin
            mem_rd    <= 1'b1;
            mem_addr  <= a_reg;
            cnt_reg   <= cnt_reg - 4'h1;
            state_reg <= S_RQ1;
          end
        end
        S_RQ1: begin
          if (two_rd) begin
            // pointer and vector pairs are fetched low byte first
            lo_reg    <= mem_rdata;
            mem_rd    <= 1'b1;
            mem_addr  <= a_reg + 16'h0001;
            cnt_reg   <= cnt_reg - 4'h1;
            state_reg <= S_RQ2;
          end
        end
        S_WAIT: begin
          if (cnt_reg <= 4'h1) begin
            done      <= 1'b1;
            busy      <= 1'b0;
            y_we      <= (kind_reg == `BJDU_K_DEC_Y);
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      if (fin_go) begin
        pc_out <= fin_pc;
        taken  <= fin_taken;
        sp_out <= need_push ? sp - 8'h02 : sp;       // [RL7] [RL11] [RL12]
        if (k == `BJDU_K_DEC_DP) begin
          // write back on the address just read
          mem_wr    <= 1'b1;
          mem_wdata <= mem_rdata - 8'h01;            // [RL9]
        end
        if (k == `BJDU_K_DEC_Y)
          y_out <= y_in - 8'h01;                     // [RL9]
        if (fin_cnt <= 4'h1) begin
          done      <= 1'b1;
          busy      <= 1'b0;
          y_we      <= (k == `BJDU_K_DEC_Y);
          state_reg <= S_IDLE;
        end else begin
          cnt_reg   <= fin_cnt - 4'h1;
          state_reg <= S_WAIT;
        end
      end
    end
  end

endmodule // bjdu_top
`default_nettype wire

// ---- tb/bjdu_monitor.sv ----
// Purpose: port checker for the branch/jump/call sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes:   operands are captured at the edge that accepts start
`timescale 1ns/1ps
`default_nettype none
module bjdu_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        start,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operand1,
  input wire logic [7:0]  operand2,
  input wire logic [15:0] pc_in,
  input wire logic [7:0]  sp_in,
  input wire logic [7:0]  y_in,
  input wire logic [7:0]  dp_page,
  input wire logic        mem_rd,
  input wire logic        flag_c,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        taken,
  input wire logic        bad_op,
  input wire logic [15:0] pc_out,
  input wire logic [7:0]  sp_out,
  input wire logic [7:0]  y_out,
  input wire logic        y_we,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata
);
  logic [15:0] pc_q;
  logic [7:0]  o1_q, o2_q, sp_q, y_q;
  wire         take = start && !busy;
  wire  [15:0] rel_t = pc_q + 16'h0002 + {{8{o1_q[7]}}, o1_q};
  wire  [15:0] ret3 = pc_q + 16'h0003;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {pc_q, o1_q, o2_q, sp_q, y_q} <= '0;
    end else if (take) begin
      {pc_q, o1_q, o2_q, sp_q, y_q} <=
        {pc_in, operand1, operand2, sp_in, y_in};
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_carry_not_taken: assert property (take && opcode == 8'h50 && flag_c
    |=> done && !taken && pc_out == pc_q + 16'h0002)
    else $error("carry branch not taken wrong");
  a_carry_taken_late: assert property (take && opcode == 8'h50 && !flag_c
    |=> !done ##1 !done ##1 done && taken && pc_out == rel_t)
    else $error("carry branch taken wrong");
  a_uncond_four: assert property (take && opcode == 8'h2f
    |=> !done [*2] ##1 done && taken && pc_out == rel_t)
    else $error("unconditional branch wrong");
  a_call_push_order: assert property (take && opcode == 8'h3b
    |=> mem_wr && mem_addr == {8'h01, sp_q} && mem_wdata == ret3[15:8]
    ##1 mem_wr && mem_addr == {8'h01, sp_q - 8'h01} && mem_wdata == ret3[7:0])
    else $error("call push wrong");
  a_call_target: assert property (take && opcode == 8'h3b
    |-> ##7 done && pc_out == {o2_q, o1_q} && sp_out == sp_q - 8'h02)
    else $error("call target wrong");
  a_upage_target: assert property (take && opcode == 8'h4f
    |-> ##5 done && pc_out == {8'hff, o1_q} && sp_out == sp_q - 8'h02)
    else $error("upper page call wrong");
  a_jump_abs: assert property (take && opcode == 8'h1b
    |-> ##2 done && !taken && pc_out == {o2_q, o1_q} && sp_out == sp_q)
    else $error("absolute jump wrong");
  a_dec_y_taken: assert property (take && opcode == 8'h7b && y_in != 8'h01
    |-> ##5 done && y_we && taken && y_out == y_q - 8'h01)
    else $error("y decrement branch wrong");
  a_y_write_done: assert property (y_we |-> done && $past(busy))
    else $error("y write outside done");
  a_ptr_read_pair: assert property (take && opcode == 8'h3f
    |=> mem_rd && !mem_wr && mem_addr == {$past(dp_page), $past(operand1)}
    ##1 mem_rd && mem_addr == {$past(dp_page, 2), $past(operand1, 2)} + 16'h0001
    ##1 done && pc_out != 16'h0000 || done)
    else $error("pointer read pair wrong");

  c_call: cover property (take && opcode == 8'h3b);
  c_taken: cover property (done && taken);
  c_bad: cover property (done && bad_op);
endmodule // bjdu_monitor

bind bjdu_top bjdu_monitor u_mon (.clk, .rst_n, .start, .opcode, .operand1,
  .operand2, .pc_in, .sp_in, .y_in, .dp_page, .mem_rd, .flag_c, .busy, .done,
  .taken, .bad_op,
  .pc_out, .sp_out, .y_out, .y_we, .mem_addr, .mem_wr, .mem_wdata);
`default_nettype wire

// ---- tb/bjdu_testbench.sv ----
// Purpose: self-checking bench for the branch/jump/call sequencer
// Assumes: data memory answers combinationally from a bench array
// Notes:   a note queue pairs each instruction with its done pulse
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
  n_fail++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module testbench;
  localparam logic [63:0] fops = 64'hb0_30_10_90_70_f0_d0_50;
  localparam logic [7:0]  inv  = 8'h69;
  logic        clk = 0, rst_n = 0, start = 0, t, bv;
  logic [7:0]  opcode = 0, operand1 = 0, operand2 = 0, acc_in = 0, x_in = 0;
  logic [7:0]  y_in = 0, sp_in = 0, dp_page = 0, a, xv, s, d, r, o;
  logic [15:0] pc_in = 0, p, v;
  logic        flag_c = 0, flag_z = 0, flag_n = 0, flag_v = 0;
  logic [3:0]  f, cnt = 0;
  wire logic   busy, done, taken, bad_op, y_we, mem_rd, mem_wr;
  wire logic [15:0] pc_out, mem_addr;
  wire logic [7:0]  sp_out, y_out, mem_wdata, mem_rdata;
  logic [7:0]  mem [0:65535];
  logic [29:0] notes [$];
  logic [29:0] nt;
  int          n_fail = 0, n_compared = 0, seed = 10, i;

  bjdu_top DUT (.clk, .rst_n, .start, .opcode, .operand1, .operand2, .pc_in,
    .acc_in, .x_in, .y_in, .sp_in, .dp_page, .flag_c, .flag_z, .flag_n,
    .flag_v, .mem_rdata, .busy, .done, .taken, .bad_op, .pc_out, .sp_out,
    .y_out, .y_we, .mem_addr, .mem_rd, .mem_wr, .mem_wdata);

  // an idle bus shows the inverse so stale data never passes for a read
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  always @(posedge clk) if (mem_wr) mem[mem_addr] <= mem_wdata;

  initial forever #4 clk = ~clk;

  function automatic logic [15:0] rt(input logic [15:0] pc,
      input logic [7:0] rl, input logic [1:0] n);
    rt = pc + {14'h0, n} + {{8{rl[7]}}, rl};
  endfunction

  task automatic give_verdict;
    if (notes.size() != 0) n_fail++;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // a second start while busy must be swallowed
  task automatic run(input logic [7:0] op, o1, o2, input logic [15:0] pc,
      input logic [7:0] y, input logic [3:0] cyc, input logic [15:0] epc,
      input logic [7:0] esp, input logic tk, bd);
    int k;
    opcode <= op; operand1 <= o1; operand2 <= o2; pc_in <= pc; y_in <= y;
    acc_in <= a; x_in <= xv; sp_in <= s; dp_page <= d;
    {flag_c, flag_z, flag_n, flag_v} <= f;
    notes.push_back({cyc, epc, esp, tk, bd});
    start <= 1'b1;
    @(posedge clk);
    if (cyc > 4'h2) opcode <= 8'h00;
    else start <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      if (k == 0 && cyc > 4'h2) start <= 1'b0;
      k++;
    end while (!done && k < 12);
  endtask

  task automatic push(input logic [15:0] ret);
    @(negedge clk);
    `CHK("push_hi", ret[15:8], mem[{8'h01, s}])
    `CHK("push_lo", ret[7:0], mem[{8'h01, s - 8'h01}])
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cnt <= (start && !busy) ? 4'h0 : cnt + 4'h1;
    if (done && notes.size() == 0) begin
      n_fail++;
      $display("mismatch notes exp 1 got 0");
    end else if (done) begin
      nt = notes.pop_front();
      `CHK("cycles", nt[29:26], cnt + 4'h2)
      `CHK("pc_out", nt[25:10], pc_out)
      `CHK("sp_out", nt[9:2], sp_out)
      `CHK("taken", nt[1], taken)
      `CHK("bad_op", nt[0], bad_op)
    end
  end

  initial begin
    #60000;
    n_fail++;
    give_verdict;
  end

  initial begin
    for (i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
    s = 8'h80; d = 8'h20; xv = 8'hf0; f = 4'h0; a = 8'h33;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 32; i++) begin
      f = $random(seed); r = $random(seed); p = $random(seed);
      t = f[3 - i[2:1]] ^ inv[i[2:0]];
      run(fops[i[2:0]*8 +: 8], r, 8'h0, p, 8'h0, t ? 4'h4 : 4'h2,
        t ? rt(p, r, 2'h2) : p + 16'h2, s, t, 1'b0);
    end
    for (i = 0; i < 32; i++) begin
      a = $random(seed); r = $random(seed); p = $random(seed);
      o = $random(seed);
      bv = i[4] ? mem[{d, o}][i[2:0]] : a[i[2:0]];
      t = bv ^ i[3];
      if (i[4]) run({i[2:0], i[3], 4'h3}, o, r, p, 8'h0, t ? 4'h7 : 4'h5,
        t ? rt(p, r, 2'h3) : p + 16'h3, s, t, 1'b0);
      else run({i[2:0], i[3], 4'h2}, r, 8'h0, p, 8'h0, t ? 4'h6 : 4'h4,
        t ? rt(p, r, 2'h2) : p + 16'h2, s, t, 1'b0);
    end
    a = 8'h33; mem[16'h2010] = 8'h33; mem[16'h2000] = 8'h34;
    run(8'h2f, 8'h80, 8'h0, 16'h0010, 8'h0, 4'h4, 16'hff92, s, 1'b1, 1'b0);
    run(8'hfd, 8'h10, 8'h05, 16'h1000, 8'h0, 4'h5, 16'h1003, s, 1'b0, 1'b0);
    run(8'hfd, 8'h00, 8'h05, 16'h1000, 8'h0, 4'h7, 16'h1008, s, 1'b1, 1'b0);
    run(8'h8d, 8'h10, 8'hfb, 16'h1000, 8'h0, 4'h8, 16'h0ffe, s, 1'b1, 1'b0);
    mem[16'h2040] = 8'h01; mem[16'h2041] = 8'h00;
    run(8'hac, 8'h40, 8'h7f, 16'h1000, 8'h0, 4'h5, 16'h1003, s, 1'b0, 1'b0);
    run(8'hac, 8'h41, 8'h7f, 16'h1000, 8'h0, 4'h7, 16'h1082, s, 1'b1, 1'b0);
    @(negedge clk);
    `CHK("dec_mem", 16'h00ff, {mem[16'h2040], mem[16'h2041]})
    @(posedge clk);
    run(8'h7b, 8'h02, 8'h0, 16'h1000, 8'h01, 4'h4, 16'h1002, s, 1'b0, 1'b0);
    run(8'h7b, 8'h02, 8'h0, 16'h1000, 8'h05, 4'h6, 16'h1004, s, 1'b1, 1'b0);
    @(negedge clk);
    `CHK("y_out", 8'h04, y_out)
    @(posedge clk);
    run(8'h1b, 8'h34, 8'h12, 16'h1000, 8'h0, 4'h3, 16'h1234, s, 1'b0, 1'b0);
    run(8'h1f, 8'hff, 8'h30, 16'h1000, 8'h0, 4'h5,
      {mem[16'h3100], mem[16'h30ff]}, s, 1'b0, 1'b0);
    run(8'h3f, 8'h50, 8'h0, 16'h1000, 8'h0, 4'h4,
      {mem[16'h2051], mem[16'h2050]}, s, 1'b0, 1'b0);
    run(8'h3b, 8'h78, 8'h56, 16'h10fe, 8'h0, 4'h8, 16'h5678, s - 8'h02,
      1'b0, 1'b0);
    push(16'h1101);
    run(8'h5f, 8'h60, 8'h0, 16'h1000, 8'h0, 4'h8,
      {mem[16'h2061], mem[16'h2060]}, s - 8'h02, 1'b0, 1'b0);
    push(16'h1002);
    run(8'h4f, 8'h9a, 8'h0, 16'h1000, 8'h0, 4'h6, 16'hff9a, s - 8'h02,
      1'b0, 1'b0);
    push(16'h1002);
    for (i = 0; i < 16; i++) begin
      v = 16'hffc0 + {11'h0, i[3:0], 1'b0};
      run({i[3:0], 4'ha}, 8'h0, 8'h0, 16'h1000, 8'h0, 4'h8,
        {mem[v + 16'h1], mem[v]}, s - 8'h02, 1'b0, 1'b0);
      push(16'h1001);
    end
    run(8'hff, 8'h0, 8'h0, 16'h2345, 8'h0, 4'h2, 16'h2345, s, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
